// file: dv/ddsl_host_model.sv
// Purpose: Host serial port model driving the load pins
// Assumes: Shift clock idles low, 4 clk (80 ns) per phase, longer at the byte gap and the last rise
// Notes:   Words go out as two bytes within one select
`timescale 1ns/1ps
module ddsl_host_model (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic chip_select_n,
   output logic shift_clk,
   output logic serial_din
);
   initial begin
      chip_select_n = 1'b1;
      shift_clk = 1'b0;
      serial_din = 1'b0;
   end
   // ----
   // Frame driver
   // ----
   // Low nbits of word, MSB first; a short word is closed by select
   task automatic send(input logic [15:0] word, input int nbits);
      chip_select_n <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         serial_din <= word[nbits-1-i];
         shift_clk <= 1'b1;
         repeat (4) @(posedge clk);
         shift_clk <= 1'b0;
         repeat (4) @(posedge clk);
         if (i == 7) repeat (8) @(posedge clk);
      end
      if (nbits == 16) begin
         // Long high phase so the load lands while it stands
         shift_clk <= 1'b1;
         repeat (8) @(posedge clk);
         shift_clk <= 1'b0;
         repeat (4) @(posedge clk);
      end
      chip_select_n <= 1'b1;
      serial_din <= ~serial_din; // Released line must not look held
      repeat (10) @(posedge clk);
   endtask
endmodule

// file: dv/ddsl_top_sva.sv
// Purpose: Port checks for the dual DAC serial load block
// Assumes: Host keeps each shift-clock phase of 4 clk or more
// Notes:   Load latency checked as a window, sync depth may vary
`timescale 1ns/1ps
module ddsl_top_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial pins
   input wire logic chip_select_n,
   input wire logic shift_clk,
   input wire logic serial_din,
   // Latches and status
   input wire logic [ddsl_pkg::DATA_BITS-1:0] dac_a_code,
   input wire logic [ddsl_pkg::DATA_BITS-1:0] dac_b_code,
   input wire logic [ddsl_pkg::DATA_BITS-1:0] buffer_code,
   input wire logic fast_mode,
   input wire logic power_down,
   input wire logic word_loaded,
   input wire logic busy
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Reset check must run while reset is low, so no disable here
   AST_RESET_CLEARS: assert property (disable iff (1'b0)
      !resetn |=> dac_a_code == '0 && dac_b_code == '0 && buffer_code == '0
      && !fast_mode && !power_down && !word_loaded && !busy)
      else $error("latches not cleared by reset");
   AST_LOAD_PULSE: assert property (word_loaded |=> !word_loaded)
      else $error("load pulse longer than one cycle");
   AST_CHANGE_LOADS: assert property ($past(resetn) &&
      ($changed(dac_a_code) || $changed(dac_b_code) ||
      $changed(buffer_code) || $changed(fast_mode) ||
      $changed(power_down)) |-> ##[0:1] word_loaded)
      else $error("latch changed without load pulse");
   AST_IDLE_NO_LOAD: assert property (
      chip_select_n [*8] |-> !word_loaded)
      else $error("load while deselected");
   AST_BUSY_START: assert property (
      $fell(chip_select_n) |-> ##[1:4] busy)
      else $error("select fall did not start a word");
   AST_BUSY_END: assert property (
      $rose(chip_select_n) |-> ##[1:6] !busy)
      else $error("busy kept after deselect");
   AST_PD_KEEPS: assert property ($rose(power_down) |->
      $stable(dac_a_code) && $stable(dac_b_code) && $stable(buffer_code))
      else $error("power-down word changed a code");
   AST_LOAD_AT_RISE: assert property (word_loaded |->
      shift_clk || chip_select_n)
      else $error("load outside commit edge");
endmodule
bind ddsl_top ddsl_top_sva ddsl_top_sva_i (.clk(clk), .resetn(resetn),
   .chip_select_n(chip_select_n), .shift_clk(shift_clk),
   .serial_din(serial_din), .dac_a_code(dac_a_code),
   .dac_b_code(dac_b_code), .buffer_code(buffer_code),
   .fast_mode(fast_mode), .power_down(power_down),
   .word_loaded(word_loaded), .busy(busy));

// file: dv/tb.sv
// Purpose: Self-checking bench for the dual DAC serial load block
// Assumes: 50 MHz clk, 160 ns shift clock from the host model
// Notes:   Expected latches kept by the bench from the word layout
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic chip_select_n, shift_clk, serial_din;
   logic [ddsl_pkg::DATA_BITS-1:0] dac_a_code, dac_b_code, buffer_code;
   logic fast_mode, power_down, word_loaded, busy;
   logic [11:0] ea, eb, ebuf;
   logic efast, epd;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int n_loads = 0;
   always #10 clk = ~clk;
   // Count load pulses so each word can be held to one or none
   always @(posedge clk) begin
      if (word_loaded === 1'b1) n_loads++;
   end
   ddsl_host_model ddsl_host_model_i (.clk(clk),
      .chip_select_n(chip_select_n), .shift_clk(shift_clk),
      .serial_din(serial_din));
   ddsl_top ddsl_top_i (.clk(clk), .resetn(resetn),
      .chip_select_n(chip_select_n), .shift_clk(shift_clk),
      .serial_din(serial_din), .dac_a_code(dac_a_code),
      .dac_b_code(dac_b_code), .buffer_code(buffer_code),
      .fast_mode(fast_mode), .power_down(power_down),
      .word_loaded(word_loaded), .busy(busy));
   // ----
   // Shared tasks
   // ----
   task automatic stop_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic check_all();
      cmp(dac_a_code, ea);
      cmp(dac_b_code, eb);
      cmp(buffer_code, ebuf);
      cmp({11'h000, fast_mode}, {11'h000, efast});
      cmp({11'h000, power_down}, {11'h000, epd});
      cmp({11'h000, busy}, 12'h000);
   endtask
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      {ea, eb, ebuf, efast, epd} = '0;
      check_all();
   endtask
   // Send one word and predict the latches; short words keep low bits
   task automatic word(input logic [15:0] w, input int n);
      logic [15:0] r;
      int n0;
      r = (n < 16) ? (w & ~(16'hffff << n)) : w;
      n0 = n_loads;
      ddsl_host_model_i.send(w, n);
      cmp(12'(n_loads - n0), {11'h000, ({r[15], r[12]} != 2'b11)});
      if ({r[15], r[12]} == 2'b11) begin
         // Reserved code keeps everything
      end else if (r[13]) begin
         epd = 1'b1;
      end else begin
         epd = 1'b0;
         efast = r[14];
         if ({r[15], r[12]} == 2'b10) begin
            eb = ebuf;
            ea = r[11:0];
         end else begin
            ebuf = r[11:0];
            if (!r[12]) eb = r[11:0];
         end
      end
      check_all();
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_codes();
      word(16'h8777, 16);
      word(16'h1123, 16);
      word(16'hc000, 16);
      word(16'h5abc, 16);
      word(16'h0fff, 16);
   endtask
   task automatic t_reserved();
      word(16'hd555, 16);
      word(16'hf000, 16);
   endtask
   task automatic t_pdown();
      word(16'h2abc, 16);
      word(16'h4321, 16);
   endtask
   task automatic t_partial();
      word(16'h0a5a, 12);
   endtask
   // Hang guard, well above the roughly 1600 cycles of the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      do_reset();
      t_codes();
      t_reserved();
      t_pdown();
      t_partial();
      do_reset();
      stop_test();
   end
endmodule

// file: rtl/ddsl_pkg.sv
// Purpose: Shared constants and types for the dual DAC serial load block
// Assumes: 16-bit command words, 12-bit unsigned DAC codes
// Notes:   Field positions follow the command word layout, MSB first
package ddsl_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int DATA_BITS = 12;
   localparam int CNT_BITS = 5;
   localparam int POS_TSEL_HIGH = 15;
   localparam int POS_SPEED = 14;
   localparam int POS_PDOWN = 13;
   localparam int POS_TSEL_LOW = 12;
   localparam int POS_DATA_MSB = 11;

   // Number of falling shift-clock edges in one complete word
   localparam logic [CNT_BITS-1:0] BITS_PER_WORD = 5'h10;

   // ----------------------------------------------------------------
   // Target select codes {high, low}
   // ----------------------------------------------------------------
   localparam logic [1:0] TSEL_DACB_BUF = 2'h0;
   localparam logic [1:0] TSEL_BUF_ONLY = 2'h1;
   localparam logic [1:0] TSEL_DACA_XFER = 2'h2;
   localparam logic [1:0] TSEL_RESERVED = 2'h3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_BITS-1:0] CODE_RESET = 12'h000;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;

   // ----------------------------------------------------------------
   // Receive state machine, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      DDSL_IDLE  = 3'b001,
      DDSL_SHIFT = 3'b010,
      DDSL_DONE  = 3'b100
   } ddsl_state_t;

endpackage

// file: rtl/ddsl_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Inputs are slow levels compared with clk
// Notes:   The first stage is read only by the second stage
`timescale 1ns/1ps

module ddsl_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Asynchronous levels in
   input wire logic [WIDTH-1:0] async_in,
   // Synchronised levels out
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // Two stages to let metastability resolve before any logic looks
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_reg <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// file: rtl/ddsl_top.sv
// Purpose: Serial load logic of a dual 12-bit DAC
// Assumes: clk at 50 MHz, serial pins asynchronous to clk
// Notes:   Pins are oversampled, so the shift clock must stay well
//          below clk/4 for edges to be seen reliably
//
// Summary of operation
// - Chip select falling edge starts a word
// - Shift data in on shift-clock falls, MSB first
// - After sixteen bits, load the selected latch
// - Chip select rising also loads current contents
// - Control bits pick DAC A, B, buffer, control
// - Reset clears every latch to zero
// - Load on rising edge after sixteenth fall
// - DAC values are unsigned twelve-bit codes
// - Word is control bits then DAC value
// - Bits 15..12 control, 11..0 value MSB first
// - Codes: 00 B+buf, 01 buf, 10 A+buf-to-B
// - Speed bit picks fast; power-down overrides
`timescale 1ns/1ps

module ddsl_top (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Serial pins from the host
   input wire logic chip_select_n,
   input wire logic shift_clk,
   input wire logic serial_din,
   // Latched DAC state
   output logic [ddsl_pkg::DATA_BITS-1:0] dac_a_code,
   output logic [ddsl_pkg::DATA_BITS-1:0] dac_b_code,
   output logic [ddsl_pkg::DATA_BITS-1:0] buffer_code,
   // Control latch
   output logic fast_mode,
   output logic power_down,
   // Status
   output logic word_loaded,
   output logic busy
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      ddsl_pkg::ddsl_state_t fsm;
      logic cs_n_prev;
      logic sclk_prev;
      logic [ddsl_pkg::CNT_BITS-1:0] bit_cnt;
      logic [ddsl_pkg::WORD_BITS-1:0] shreg;
      logic [ddsl_pkg::DATA_BITS-1:0] dac_a;
      logic [ddsl_pkg::DATA_BITS-1:0] dac_b;
      logic [ddsl_pkg::DATA_BITS-1:0] buffer;
      logic fast;
      logic pdown;
      logic loaded;
   } ddsl_regs_t;

   ddsl_regs_t st_reg;
   ddsl_regs_t st_next;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic cs_n_s;
   logic sclk_s;
   logic din_s;

   // Select idles high so a reset never looks like a word start
   ddsl_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h4)
   ) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .async_in({chip_select_n, shift_clk, serial_din}),
      .sync_out(pins_sync)
   );

   assign cs_n_s = pins_sync[2];
   assign sclk_s = pins_sync[1];
   assign din_s = pins_sync[0];

   // ----------------------------------------------------------------
   // Edge detection on the synchronised pins
   // ----------------------------------------------------------------
   logic cs_fall;
   logic cs_rise;
   logic sclk_fall;
   logic sclk_rise;
   logic full_word;

   // Compare against the copy held one cycle back
   assign cs_fall = st_reg.cs_n_prev & ~cs_n_s;
   assign cs_rise = ~st_reg.cs_n_prev & cs_n_s;
   assign sclk_fall = st_reg.sclk_prev & ~sclk_s;
   assign sclk_rise = ~st_reg.sclk_prev & sclk_s;
   assign full_word = (st_reg.bit_cnt == ddsl_pkg::BITS_PER_WORD);

   // ----------------------------------------------------------------
   // Word decode into the latches
   // ----------------------------------------------------------------
   // Applies one received word to a copy of the state and returns it
   function automatic ddsl_regs_t apply_word(
      input ddsl_regs_t s,
      input logic [ddsl_pkg::WORD_BITS-1:0] w
   );
      logic [1:0] tsel;
      logic [ddsl_pkg::DATA_BITS-1:0] code;
      ddsl_regs_t r;
      r = s;
      tsel = {w[ddsl_pkg::POS_TSEL_HIGH],
              w[ddsl_pkg::POS_TSEL_LOW]};
      code = w[ddsl_pkg::POS_DATA_MSB:0];
      if (tsel == ddsl_pkg::TSEL_RESERVED) begin
         r.loaded = 1'b0;
      end else if (w[ddsl_pkg::POS_PDOWN]) begin
         // Power-down wins; the other fields are don't care
         r.pdown = 1'b1;
      end else begin
         r.pdown = 1'b0;
         r.fast = w[ddsl_pkg::POS_SPEED];
         case (tsel)
            ddsl_pkg::TSEL_DACB_BUF: begin
               r.dac_b = code;
               r.buffer = code;
            end
            ddsl_pkg::TSEL_BUF_ONLY: begin
               r.buffer = code;
            end
            ddsl_pkg::TSEL_DACA_XFER: begin
               // Old buffer moves to B in the same cycle A loads
               r.dac_a = code;
               r.dac_b = s.buffer;
            end
            default: begin
               r.buffer = s.buffer;
            end
         endcase
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Receive sequencing, shift register and latch updates
   always_comb begin
      st_next = st_reg;
      st_next.cs_n_prev = cs_n_s;
      st_next.sclk_prev = sclk_s;
      st_next.loaded = 1'b0;
      case (st_reg.fsm)
         ddsl_pkg::DDSL_IDLE: begin
            if (cs_fall) begin
               st_next.fsm = ddsl_pkg::DDSL_SHIFT;
               st_next.bit_cnt = ddsl_pkg::CNT_RESET;
               st_next.shreg = ddsl_pkg::WORD_RESET;
               // Select and first fall may land in one sample
               if (sclk_fall) begin
                  st_next.shreg = {ddsl_pkg::WORD_RESET[
                     ddsl_pkg::WORD_BITS-2:0], din_s};
                  st_next.bit_cnt = ddsl_pkg::CNT_RESET + 5'h01;
               end
            end
         end
         ddsl_pkg::DDSL_SHIFT: begin
            if (cs_rise) begin
               // Early end of frame loads what has arrived so far
               if (st_reg.bit_cnt != ddsl_pkg::CNT_RESET) begin
                  st_next = apply_word(st_next, st_reg.shreg);
                  st_next.loaded = 1'b1;
               end
               st_next.fsm = ddsl_pkg::DDSL_IDLE;
            end else if (full_word) begin
               if (sclk_rise) begin
                  st_next = apply_word(st_next, st_reg.shreg);
                  st_next.loaded = 1'b1;
                  st_next.fsm = ddsl_pkg::DDSL_DONE;
               end
            end else if (sclk_fall) begin
               // Two byte writes in one select fill one word
               st_next.shreg = {st_reg.shreg[
                  ddsl_pkg::WORD_BITS-2:0], din_s};
               st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            end
         end
         ddsl_pkg::DDSL_DONE: begin
            // Extra clocks after a full word are ignored
            if (cs_rise) begin
               st_next.fsm = ddsl_pkg::DDSL_IDLE;
            end
         end
         default: begin
            st_next.fsm = ddsl_pkg::DDSL_IDLE;
         end
      endcase
      // Reserved words report nothing loaded
      if (st_next.loaded && (st_next.dac_a == st_reg.dac_a) &&
          (st_next.dac_b == st_reg.dac_b) &&
          (st_next.buffer == st_reg.buffer) &&
          (st_next.fast == st_reg.fast) &&
          (st_next.pdown == st_reg.pdown) &&
          ({st_reg.shreg[ddsl_pkg::POS_TSEL_HIGH],
            st_reg.shreg[ddsl_pkg::POS_TSEL_LOW]} ==
           ddsl_pkg::TSEL_RESERVED)) begin
         st_next.loaded = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Synchronous reset clears every latch to zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg.fsm <= ddsl_pkg::DDSL_IDLE;
         st_reg.cs_n_prev <= 1'b1;
         st_reg.sclk_prev <= 1'b0;
         st_reg.bit_cnt <= ddsl_pkg::CNT_RESET;
         st_reg.shreg <= ddsl_pkg::WORD_RESET;
         st_reg.dac_a <= ddsl_pkg::CODE_RESET;
         st_reg.dac_b <= ddsl_pkg::CODE_RESET;
         st_reg.buffer <= ddsl_pkg::CODE_RESET;
         st_reg.fast <= 1'b0;
         st_reg.pdown <= 1'b0;
         st_reg.loaded <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign dac_a_code = st_reg.dac_a;
   assign dac_b_code = st_reg.dac_b;
   assign buffer_code = st_reg.buffer;
   assign fast_mode = st_reg.fast;
   assign power_down = st_reg.pdown;
   assign word_loaded = st_reg.loaded;
   assign busy = st_reg.fsm[1]; // One-hot bit of the shift state

endmodule
